// ---- rtl/lfs_params.svh ----
// Purpose: Constants of the lamp fault supervisor.
// Assumes: Core clock of 100 MHz.
// Notes:   Times keep their printed unit; cycle counts derive from them.
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH
`define LFS_CLK_MHZ      100
`define LFS_DEAD_NS      1800
`define LFS_DEAD_CYC     ((`LFS_DEAD_NS * `LFS_CLK_MHZ) / 1000)
`define LFS_WEAR_US      610
`define LFS_ASYM_MS      500
`define LFS_PRERUN_MS    250
`define LFS_US_CYC(t)    ((t) * `LFS_CLK_MHZ)
`define LFS_MS_CYC(t)    ((t) * `LFS_CLK_MHZ * 1000)
`define LFS_REM_CYCLES   6'h20
`define LFS_CTRL_ADDR    4'h0
`define LFS_STAT_ADDR    4'h4
`define LFS_CTRL_RST     1'b1
`define LFS_CTRL_DRV_BIT 0
`endif

// ---- rtl/lfs_pkg.sv ----
// Purpose: Types of the lamp fault supervisor.
// Assumes: Used together with lfs_params.svh.
// Notes:   All module state travels as one packed struct.
package lfs_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_CHECK = 3'b001, ST_INHIBIT = 3'b010,
    ST_START = 3'b011, ST_PRERUN = 3'b100, ST_RUN = 3'b101,
    ST_FDELAY = 3'b110, ST_FAULT = 3'b111
  } lfs_state_t;
  typedef enum logic [2:0] {
    SRC_OFF = 3'b000, SRC_NOMINAL = 3'b001, SRC_REDUCED = 3'b010,
    SRC_HS_UPPER = 3'b011, SRC_HS_LOWER = 3'b100
  } lfs_src_t;
  typedef enum logic [1:0] {
    THR_UPPER = 2'b00, THR_LOWER = 2'b01, THR_DISCHARGE = 2'b10
  } lfs_thr_t;
  typedef struct packed {
    logic sink;
    logic proof;
    logic grounded;
    logic over;
    logic dc;
    logic dc_over;
    logic ratio_bad;
  } lfs_chan_t;
  typedef struct packed {
    logic            supply_ok;
    logic            supply_start;
    logic            res_above;
    logic            res_below_disch;
    logic            hs_upper;
    logic            hs_lower;
    logic            run_freq;
    lfs_chan_t [1:0] lvs;
  } lfs_pins_t;
  typedef struct packed {
    lfs_pins_t        s1;
    lfs_pins_t        s2;
    lfs_state_t       state;
    logic             ls_open;
    logic             hs_open;
    logic             wear;
    logic             asym;
    logic [1:0][25:0] wear_cnt;
    logic [1:0][25:0] asym_cnt;
    logic [25:0]      prerun_cnt;
    logic [5:0]       rem_cnt;
    logic             discharging;
    logic             phase;
    logic [7:0]       dead;
    logic             hs_ok;
    logic             lo;
    logic             hi;
    lfs_src_t         src;
    lfs_thr_t         thr;
    logic             drv_en;
    logic             ack;
    logic [31:0]      rdata;
  } lfs_regs_t;
endpackage : lfs_pkg

// ---- rtl/lfs_supervisor.sv ----
// Purpose: Filament checks, lamp fault latch, removal delay, gate gating.
// Assumes: Comparator flags arrive asynchronously; gate phase is local.
// Notes:   Registers are reached over Avalon-MM with waitrequest.
`timescale 1ns/1ps
`include "lfs_params.svh"

// Functional notes
// - Above lockout with pin below upper threshold, source 20 uA.
// - Pin above upper threshold means open low filament; start-up held off.
// - Then lower threshold and 17 uA; start-up freed once pin drops below.
// - No sink current on both sense pins before start threshold: high open.
// - High filament open: 41 uA at upper, 34 uA at lower threshold.
// - A lamp fault turns both gate drives off.
// - After fault, 32 charge/discharge cycles delay removal detection.
// - Each enabled sense pin must show presence sink before softstart.
// - Run mode: peak over 215 uA for over 610 us is wear fault.
// - Amplitude ratio out of band for over 500 ms is asymmetry fault.
// - Either fault latches until lamp removal or supply cycle.
// - DC sense without zero crossings trips wear only above 175 uA.
// - Second sense channel behaves identically to the first.
// - High section on at upper floating supply, off at lower.
// - High gate drive stays low during undervoltage lockout.
// - Dead time of 1800 ns between low and high gate drives.
// - Monitors stay off for 250 ms pre-run after run frequency.
// - Start-up threshold ends the pre-start filament checks.
// - Dropping below lockout level clears filament inhibit.
module lfs_supervisor #(
  parameter int unsigned WEAR_CYC   = `LFS_US_CYC(`LFS_WEAR_US),
  parameter int unsigned ASYM_CYC   = `LFS_MS_CYC(`LFS_ASYM_MS),
  parameter int unsigned PRERUN_CYC = `LFS_MS_CYC(`LFS_PRERUN_MS)
) (
  // Clock and reset.
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  // Comparator flags from the analog front end.
  input  wire lfs_pkg::lfs_pins_t pins_i,
  // Half-bridge phase request from the frequency generator.
  input  wire logic             gate_phase_i,
  // Avalon-MM slave.
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic [31:0]           avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // Analog control and gate drives.
  output lfs_pkg::lfs_src_t     removal_source_o,
  output lfs_pkg::lfs_thr_t     removal_threshold_o,
  output logic                  removal_discharge_o,
  output logic                  startup_enable_o,
  output logic                  low_gate_drive_o,
  output logic                  high_gate_drive_o,
  output logic                  lamp_peak_wear_fault_o,
  output logic                  lamp_asymmetry_fault_o,
  output lfs_pkg::lfs_state_t   mode_o
);

  lfs_pkg::lfs_regs_t r_ff;
  lfs_pkg::lfs_regs_t nxt_r;

  function automatic logic reached(input logic [25:0] cnt,
                                   input int unsigned lim);
    reached = ({6'h00, cnt} >= lim);
  endfunction : reached

  function automatic logic [25:0] bump(input logic [25:0] cnt);
    bump = (cnt == 26'h3FFFFFF) ? cnt : cnt + 26'h0000001;
  endfunction : bump

  logic req;
  logic drive_on;
  logic presence_ok;
  logic sink_any;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~r_ff.ack;
  assign avs_readdata_o    = r_ff.rdata;
  assign removal_source_o  = r_ff.src;
  assign removal_threshold_o = r_ff.thr;
  assign removal_discharge_o = r_ff.discharging;
  assign low_gate_drive_o  = r_ff.lo;
  assign high_gate_drive_o = r_ff.hi;
  assign lamp_peak_wear_fault_o = r_ff.wear;
  assign lamp_asymmetry_fault_o = r_ff.asym;
  assign mode_o            = r_ff.state;
  assign startup_enable_o  = (r_ff.state == lfs_pkg::ST_START) |
                             (r_ff.state == lfs_pkg::ST_PRERUN) |
                             (r_ff.state == lfs_pkg::ST_RUN);

  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = pins_i;
    nxt_r.s2 = r_ff.s1;
    presence_ok = 1'b1;
    sink_any = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (!r_ff.s2.lvs[i].grounded) begin
        presence_ok = presence_ok & r_ff.s2.lvs[i].proof;
        sink_any = sink_any | r_ff.s2.lvs[i].sink;
      end
    end

    case (r_ff.state)
      lfs_pkg::ST_OFF: begin
        if (r_ff.s2.supply_ok) begin
          nxt_r.state = lfs_pkg::ST_CHECK;
        end
      end
      lfs_pkg::ST_CHECK: begin
        nxt_r.hs_open = ~sink_any;
        if (r_ff.s2.res_above) begin
          nxt_r.ls_open = 1'b1;
          nxt_r.state = lfs_pkg::ST_INHIBIT;
        end else if (r_ff.s2.supply_start && !r_ff.hs_open &&
                     presence_ok) begin
          nxt_r.state = lfs_pkg::ST_START;
        end
      end
      lfs_pkg::ST_INHIBIT: begin
        if (!r_ff.s2.res_above) begin
          nxt_r.ls_open = 1'b0;
          nxt_r.state = lfs_pkg::ST_CHECK;
        end
      end
      lfs_pkg::ST_START: begin
        nxt_r.prerun_cnt = 26'h0000000;
        if (r_ff.s2.run_freq) begin
          nxt_r.state = lfs_pkg::ST_PRERUN;
        end
      end
      lfs_pkg::ST_PRERUN: begin
        nxt_r.prerun_cnt = bump(r_ff.prerun_cnt);
        if (reached(r_ff.prerun_cnt, PRERUN_CYC)) begin
          nxt_r.state = lfs_pkg::ST_RUN;
        end
      end
      lfs_pkg::ST_RUN: begin
        for (int i = 0; i < 2; i++) begin
          if (!r_ff.s2.lvs[i].grounded &&
              (r_ff.s2.lvs[i].dc ? r_ff.s2.lvs[i].dc_over
                                 : r_ff.s2.lvs[i].over)) begin
            nxt_r.wear_cnt[i] = bump(r_ff.wear_cnt[i]);
          end else begin
            nxt_r.wear_cnt[i] = 26'h0000000;
          end
          if (!r_ff.s2.lvs[i].grounded && r_ff.s2.lvs[i].ratio_bad) begin
            nxt_r.asym_cnt[i] = bump(r_ff.asym_cnt[i]);
          end else begin
            nxt_r.asym_cnt[i] = 26'h0000000;
          end
          if (reached(r_ff.wear_cnt[i], WEAR_CYC)) begin
            nxt_r.wear = 1'b1;
          end
          if (reached(r_ff.asym_cnt[i], ASYM_CYC)) begin
            nxt_r.asym = 1'b1;
          end
        end
        if (nxt_r.wear || nxt_r.asym) begin
          nxt_r.state = lfs_pkg::ST_FDELAY;
          nxt_r.rem_cnt = 6'h00;
          nxt_r.discharging = 1'b0;
        end
      end
      lfs_pkg::ST_FDELAY: begin
        if (!r_ff.discharging && r_ff.s2.res_above) begin
          nxt_r.discharging = 1'b1;
        end else if (r_ff.discharging && r_ff.s2.res_below_disch) begin
          nxt_r.discharging = 1'b0;
          nxt_r.rem_cnt = r_ff.rem_cnt + 6'h01;
          if (r_ff.rem_cnt == `LFS_REM_CYCLES - 6'h01) begin
            nxt_r.state = lfs_pkg::ST_FAULT;
          end
        end
      end
      lfs_pkg::ST_FAULT: begin
        if (r_ff.s2.res_above) begin
          nxt_r.wear = 1'b0;
          nxt_r.asym = 1'b0;
          nxt_r.state = lfs_pkg::ST_CHECK;
        end
      end
      default: begin
        nxt_r.state = lfs_pkg::ST_OFF;
      end
    endcase

    if (nxt_r.state != lfs_pkg::ST_RUN) begin
      nxt_r.wear_cnt = '0;
      nxt_r.asym_cnt = '0;
    end

    if (!r_ff.s2.supply_ok) begin
      nxt_r.state = lfs_pkg::ST_OFF;
      nxt_r.ls_open = 1'b0;
      nxt_r.hs_open = 1'b0;
      nxt_r.wear = 1'b0;
      nxt_r.asym = 1'b0;
      nxt_r.discharging = 1'b0;
    end

    // Removal source and comparator threshold follow the next state.
    case (nxt_r.state)
      lfs_pkg::ST_OFF: begin
        nxt_r.src = lfs_pkg::SRC_OFF;
        nxt_r.thr = lfs_pkg::THR_UPPER;
      end
      lfs_pkg::ST_CHECK: begin
        nxt_r.src = nxt_r.hs_open ? lfs_pkg::SRC_HS_UPPER
                                  : lfs_pkg::SRC_NOMINAL;
        nxt_r.thr = lfs_pkg::THR_UPPER;
      end
      lfs_pkg::ST_INHIBIT: begin
        nxt_r.src = nxt_r.hs_open ? lfs_pkg::SRC_HS_LOWER
                                  : lfs_pkg::SRC_REDUCED;
        nxt_r.thr = lfs_pkg::THR_LOWER;
      end
      lfs_pkg::ST_FDELAY: begin
        nxt_r.src = nxt_r.discharging ? lfs_pkg::SRC_OFF
                                      : lfs_pkg::SRC_NOMINAL;
        nxt_r.thr = nxt_r.discharging ? lfs_pkg::THR_DISCHARGE
                                      : lfs_pkg::THR_UPPER;
      end
      default: begin
        nxt_r.src = lfs_pkg::SRC_NOMINAL;
        nxt_r.thr = lfs_pkg::THR_UPPER;
      end
    endcase

    // Floating supply hysteresis.
    if (!r_ff.s2.supply_ok || !r_ff.s2.hs_lower) begin
      nxt_r.hs_ok = 1'b0;
    end else if (r_ff.s2.hs_upper) begin
      nxt_r.hs_ok = 1'b1;
    end

    // Dead time: any phase change blanks both drives first.
    if (gate_phase_i != r_ff.phase) begin
      nxt_r.phase = gate_phase_i;
      nxt_r.dead = 8'(`LFS_DEAD_CYC);
    end else if (r_ff.dead != 8'h00) begin
      nxt_r.dead = r_ff.dead - 8'h01;
    end
    drive_on = r_ff.drv_en && (nxt_r.dead == 8'h00) &&
               ((nxt_r.state == lfs_pkg::ST_START) ||
                (nxt_r.state == lfs_pkg::ST_PRERUN) ||
                (nxt_r.state == lfs_pkg::ST_RUN));
    nxt_r.lo = drive_on & ~nxt_r.phase;
    nxt_r.hi = drive_on & nxt_r.phase & nxt_r.hs_ok;

    // Bus slave: one wait cycle, then the answer.
    nxt_r.ack = req & ~r_ff.ack;
    if (req && !r_ff.ack) begin
      case (avs_address_i)
        `LFS_CTRL_ADDR: nxt_r.rdata = {31'h00000000, r_ff.drv_en};
        `LFS_STAT_ADDR: nxt_r.rdata = {18'h00000, r_ff.rem_cnt,
                                       startup_enable_o, r_ff.asym,
                                       r_ff.wear, r_ff.hs_open,
                                       r_ff.ls_open, r_ff.state};
        default:        nxt_r.rdata = 32'h00000000;
      endcase
    end
    if (avs_write_i && r_ff.ack && avs_byteenable_i[0] &&
        avs_address_i == `LFS_CTRL_ADDR) begin
      nxt_r.drv_en = avs_writedata_i[`LFS_CTRL_DRV_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r_ff <= '0;
      r_ff.drv_en <= `LFS_CTRL_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule : lfs_supervisor

// ---- tb/lfs_checker.sv ----
// Purpose: Port assertions of the lamp fault supervisor.
// Assumes: Bound into every lfs_supervisor instance.
// Notes:   Outputs change on the same edge as the state; state checks other than AST_INHIBIT_HOLD still span two cycles.
`timescale 1ns/1ps
module lfs_checker (
  input wire logic                sys_clk_i,
  input wire logic                reset_i,
  input wire logic                low_gate_drive_o,
  input wire logic                high_gate_drive_o,
  input wire logic                startup_enable_o,
  input wire lfs_pkg::lfs_src_t   removal_source_o,
  input wire lfs_pkg::lfs_thr_t   removal_threshold_o,
  input wire lfs_pkg::lfs_state_t mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  AST_NO_OVERLAP: assert property (!(low_gate_drive_o && high_gate_drive_o))
    else $error("gate drives overlap");
  AST_DEAD_TIME: assert property ($fell(low_gate_drive_o) |-> !high_gate_drive_o [*8])
    else $error("dead time short");
  AST_LOCKOUT_HIGH: assert property ((mode_o == lfs_pkg::ST_OFF) [*2] |-> !high_gate_drive_o)
    else $error("high drive in lockout");
  AST_FAULT_DRIVES: assert property ((mode_o[2:1] == 2'b11) [*2] |->
    !(low_gate_drive_o || high_gate_drive_o)) else $error("drives on in fault");
  AST_INHIBIT_HOLD: assert property (mode_o == lfs_pkg::ST_INHIBIT |-> !startup_enable_o)
    else $error("start-up while inhibited");
  AST_INHIBIT_SRC: assert property ((mode_o == lfs_pkg::ST_INHIBIT) [*2] |->
    removal_threshold_o == lfs_pkg::THR_LOWER &&
    removal_source_o inside {lfs_pkg::SRC_REDUCED, lfs_pkg::SRC_HS_LOWER}) else $error("inhibit src");
  AST_CHECK_SRC: assert property ((mode_o == lfs_pkg::ST_CHECK) [*2] |->
    removal_threshold_o == lfs_pkg::THR_UPPER &&
    removal_source_o inside {lfs_pkg::SRC_NOMINAL, lfs_pkg::SRC_HS_UPPER}) else $error("check src");
  AST_FAULT_ENTRY: assert property (mode_o == lfs_pkg::ST_FAULT &&
    $past(mode_o) != lfs_pkg::ST_FAULT |-> $past(mode_o) == lfs_pkg::ST_FDELAY)
    else $error("fault without delay");
  COV_RUN: cover property (mode_o == lfs_pkg::ST_RUN);
  COV_INHIBIT: cover property (mode_o == lfs_pkg::ST_INHIBIT);
  COV_FAULT: cover property (mode_o == lfs_pkg::ST_FAULT);
endmodule : lfs_checker
bind lfs_supervisor lfs_checker chk_u (.sys_clk_i, .reset_i, .low_gate_drive_o,
  .high_gate_drive_o, .startup_enable_o, .removal_source_o, .removal_threshold_o, .mode_o);

// ---- tb/lfs_front_model.sv ----
// Purpose: Removal pin capacitor and comparator model.
// Assumes: Pin level in steps of 0.1 V, one step per clock.
// Notes:   cap_max_i is the level the pin settles at while charged.
`timescale 1ns/1ps
module lfs_front_model (
  input  wire logic               sys_clk_i,
  input  wire lfs_pkg::lfs_pins_t knob_i,
  input  wire logic [4:0]         cap_max_i,
  input  wire lfs_pkg::lfs_src_t  src_i,
  input  wire lfs_pkg::lfs_thr_t  thr_i,
  input  wire logic               disch_i,
  output lfs_pkg::lfs_pins_t      pins_o
);
  logic [4:0] lvl = 5'h00;
  logic [4:0] thr;
  always_ff @(posedge sys_clk_i) begin
    if (disch_i || src_i == lfs_pkg::SRC_OFF || lvl > cap_max_i) begin
      lvl <= (lvl != 5'h00) ? lvl - 5'h01 : 5'h00;
    end else if (lvl < cap_max_i) begin
      lvl <= lvl + 5'h01;
    end
  end
  always_comb begin
    thr = (thr_i == lfs_pkg::THR_LOWER) ? 5'h0D : (thr_i == lfs_pkg::THR_DISCHARGE) ? 5'h04 : 5'h10;
    pins_o = knob_i;
    pins_o.res_above = lvl > thr;
    pins_o.res_below_disch = lvl < 5'h04;
  end
endmodule : lfs_front_model

// ---- tb/lfs_supervisor_test.sv ----
// Purpose: Self-checking bench of the lamp fault supervisor.
// Assumes: The front-end model closes the removal pin loop.
// Notes:   Long counts are shortened through parameters.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module lfs_supervisor_test;
  localparam int PRE = 30;
  localparam int WEAR = 20;
  localparam int ASYM = 40;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic gate_phase_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o, removal_discharge_o, startup_enable_o, low_gate_drive_o;
  logic high_gate_drive_o, lamp_peak_wear_fault_o, lamp_asymmetry_fault_o;
  lfs_pkg::lfs_src_t removal_source_o;
  lfs_pkg::lfs_thr_t removal_threshold_o;
  lfs_pkg::lfs_state_t mode_o;
  lfs_pkg::lfs_pins_t knob = '0;
  lfs_pkg::lfs_pins_t pins;
  logic [4:0] cap = 5'h08;
  int num_errors = 0;
  int compares = 0;
  int waited;
  // Row: ok, start, sink, proof, run, over, pin level, expected mode.
  logic [13:0] rows [10] = '{14'h0040, 14'h2841, 14'h28A2, 14'h2841, 14'h3C43,
                             14'h3E44, 14'h3E45, 14'h3FA6, 14'h2041, 14'h20A2};
  lfs_front_model fm_u (.sys_clk_i, .knob_i(knob), .cap_max_i(cap), .src_i(removal_source_o),
    .thr_i(removal_threshold_o), .disch_i(removal_discharge_o), .pins_o(pins));
  lfs_supervisor #(.WEAR_CYC(WEAR), .ASYM_CYC(ASYM), .PRERUN_CYC(PRE)) dut_u (.sys_clk_i,
    .reset_i, .pins_i(pins), .gate_phase_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
    .removal_source_o, .removal_threshold_o, .removal_discharge_o, .startup_enable_o,
    .low_gate_drive_o, .high_gate_drive_o, .lamp_peak_wear_fault_o,
    .lamp_asymmetry_fault_o, .mode_o);
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task wait_until(input lfs_pkg::lfs_state_t m);
    for (waited = 0; waited < 3000 && mode_o !== m; waited++) @(negedge sys_clk_i);
    if (waited == 3000) begin
      num_errors++;
      give_verdict();
    end
  endtask : wait_until
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // Request stands until the rising edge that samples waitrequest low.
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (i == 50) begin
      num_errors++;
      give_verdict();
    end
  endtask : bus
  task run_rows(input int a, input int b);
    logic [13:0] r;
    for (int k = a; k <= b; k++) begin
      r = rows[k];
      @(posedge sys_clk_i);
      knob.supply_ok <= r[13];
      knob.supply_start <= r[12];
      knob.run_freq <= r[9];
      cap <= r[7:3];
      for (int c = 0; c < 2; c++) begin
        knob.lvs[c].sink <= r[11];
        knob.lvs[c].proof <= r[10];
        knob.lvs[c].over <= r[8];
      end
      wait_until(lfs_pkg::lfs_state_t'(r[2:0]));
      repeat (2) @(negedge sys_clk_i);
      `CHK("mode", r[2:0], mode_o)
      `CHK("startup", r[2:0] inside {3'h3, 3'h4, 3'h5}, startup_enable_o)
    end
  endtask : run_rows
  initial begin
    knob.hs_upper = 1'b1;
    knob.hs_lower = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    run_rows(0, 4);
    @(posedge sys_clk_i);
    gate_phase_i <= 1'b1;
    for (waited = 0; waited < 400 && high_gate_drive_o !== 1'b1; waited++) @(negedge sys_clk_i);
    `CHK("dead time", 1'b1, waited >= 180 && waited <= 184)
    @(posedge sys_clk_i);
    knob.hs_upper <= 1'b0;
    knob.hs_lower <= 1'b0;
    repeat (6) @(negedge sys_clk_i);
    `CHK("high off", 1'b0, high_gate_drive_o)
    @(posedge sys_clk_i);
    knob.hs_upper <= 1'b1;
    knob.hs_lower <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    repeat (6) @(negedge sys_clk_i);
    `CHK("drives", 2'b00, {low_gate_drive_o, high_gate_drive_o})
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    run_rows(5, 6);
    `CHK("prerun", 1'b1, waited >= PRE - 3)
    run_rows(7, 7);
    `CHK("wear", 1'b1, lamp_peak_wear_fault_o)
    `CHK("wear time", 1'b1, waited >= WEAR)
    wait_until(lfs_pkg::ST_FAULT);
    @(posedge sys_clk_i);
    cap <= 5'h00;
    bus(1'b0, 4'h4, 32'h0);
    `CHK("cycles", 6'h20, rd[13:8])
    `CHK("latched", 3'h7, rd[2:0])
    @(posedge sys_clk_i);
    cap <= 5'h14;
    wait_until(lfs_pkg::ST_CHECK);
    run_rows(0, 0);
    `CHK("cleared", 1'b0, lamp_peak_wear_fault_o)
    @(posedge sys_clk_i);
    knob.lvs[1].grounded <= 1'b1;
    knob.lvs[1].ratio_bad <= 1'b1;
    run_rows(1, 6);
    @(posedge sys_clk_i);
    knob.lvs[0].dc <= 1'b1;
    knob.lvs[0].over <= 1'b1;
    repeat (80) @(negedge sys_clk_i);
    `CHK("dc wear", 1'b0, lamp_peak_wear_fault_o)
    `CHK("grounded", 1'b0, lamp_asymmetry_fault_o)
    @(posedge sys_clk_i);
    knob.lvs[1].grounded <= 1'b0;
    wait_until(lfs_pkg::ST_FDELAY);
    `CHK("asym", 1'b1, lamp_asymmetry_fault_o)
    `CHK("asym time", 1'b1, waited >= ASYM)
    run_rows(0, 0);
    run_rows(8, 8);
    `CHK("hs open src", lfs_pkg::SRC_HS_UPPER, removal_source_o)
    run_rows(9, 9);
    `CHK("hs open low", lfs_pkg::SRC_HS_LOWER, removal_source_o)
    run_rows(0, 0);
    give_verdict();
  end
endmodule : lfs_supervisor_test
